// ---- hdl/sysbus_if_unit.sv ----
// System bus interface unit: address and data tenures, snoop, parity
// ------------
// Functional notes
// - Separate address and data buses, each with own arbitration and control
// - Direct-store segment access raises storage exception, no bus cycle
// - 36-bit address with 5 odd parity bits generated by driver
// - 64-bit data with 8 odd parity bits; no 32-bit mode
// - Extended protocol: 16 out-of-order transactions tagged by 4-bit index
// - Legacy protocol ignores transaction index; data completes in order
// - Legacy protocol: at most 16 outstanding, 15 waiting plus one active
// - Latch snoop address, check caches, push modified line on hit
// - Address-only transactions carry no data tenure
// - Loads before stores unless an address dependency exists
// - Single-beat transfers of 1,2,3,4 or 8 bytes for uncached stores
// - Extended only: two-beat 16-byte bursts for vector and inhibited fetch cases that are not block moves
// - Whole cache block moves use four-beat 32-byte bursts
// - Request and await grant separately for address and data bus
// - All inputs sampled and outputs driven on rising clock edge
// - Every beat terminated; burst ends at last beat; retry repeats
// - Address termination closes address tenure; retry repeats address
// - Drive size, burst, write-through and inhibited attributes with address
// - Assert transfer start when address tenure begins
// - Bus clock equals system clock; duty cycle irrelevant
// - Active-low asserted low; parity and type asserted high
// - Protocol latched at hard reset release from bus-mode input
// ------------
`timescale 1ns/10ps
module sysbus_if_unit import sysbus_pkg::*; #(
  parameter int DEPTH = MAX_OUTSTD
) (
  input  wire logic                   mclk,              // Bus clock, same as system clock
  input  wire logic                   rst,               // Synchronous reset, high
  input  wire logic                   ce,                // Clock enable
  input  wire logic                   hard_reset_n,      // Hard reset pin
  input  wire logic                   bus_protocol_select_n, // Low selects extended
  input  wire logic                   ld_valid,          // Load queue request
  output logic                        ld_ready,          // Load queue accepted
  input  wire core_req_s              ld_req,            // Load queue payload
  input  wire logic                   st_valid,          // Store queue request
  output logic                        st_ready,          // Store queue accepted
  input  wire core_req_s              st_req,            // Store queue payload
  input  wire logic [DATA_W-1:0]      st_data,           // Store data
  output logic                        dsi_exc,           // Storage exception pulse
  output logic                        rd_valid,          // Read beat to core
  output logic [DATA_W-1:0]           rd_data,           // Read beat data
  output logic [TXN_IDX_W-1:0]        rd_tag,            // Read beat transaction slot
  output logic                        abus_req_n,        // Address bus request
  input  wire logic                   abus_grant_n,      // Address bus grant
  output logic                        transfer_start_n,  // Transfer start
  output addr_bus_s                   abus_out,          // Address and attributes
  output logic                        abus_oe,           // Address drive enable
  input  wire logic [ADDR_W-1:0]      abus_in,           // Snooped address
  input  wire logic [ADDR_PAR_W-1:0]  abus_par_in,       // Snooped address parity
  input  wire logic                   snoop_ts_n,        // Other master transfer start
  input  wire logic                   addr_ack_n,        // Address termination
  input  wire logic                   address_retry_n,   // Address retry
  output logic                        dbus_req_n,        // Data bus request
  input  wire logic                   dbus_grant_n,      // Data bus grant
  output logic [DATA_W-1:0]           dbus_out,          // Write data
  output logic [DATA_PAR_W-1:0]       dbus_par_out,      // Write data parity
  output logic                        dbus_oe,           // Data drive enable
  input  wire logic [DATA_W-1:0]      dbus_in,           // Read data
  input  wire logic [DATA_PAR_W-1:0]  dbus_par_in,       // Read data parity
  input  wire logic                   data_ack_n,        // Data beat termination
  input  wire logic                   data_retry_n,      // Data beat repeat
  input  wire logic [TXN_IDX_W-1:0]   data_txn_index,    // Returning tenure index
  output logic                        snoop_lookup,      // Snoop probe to caches
  output logic [ADDR_W-1:0]           snoop_addr,        // Latched snoop address
  input  wire logic                   snoop_hit_mod,     // Probe hit a modified line
  output logic                        extended_mode,     // Latched protocol variant
  output logic                        addr_par_err,      // Address parity error pulse
  output logic                        data_par_err       // Data parity error pulse
);

  function automatic logic [ADDR_PAR_W-1:0] addr_par(input logic [ADDR_W-1:0] a);
    logic [39:0] w;
    w = {4'h0, a};
    for (int i = 0; i < ADDR_PAR_W; i++) begin
      addr_par[i] = odd_par8(w[i*8 +: 8]);
    end
  endfunction : addr_par

  function automatic logic [DATA_PAR_W-1:0] data_par(input logic [DATA_W-1:0] d);
    for (int i = 0; i < DATA_PAR_W; i++) begin
      data_par[i] = odd_par8(d[i*8 +: 8]);
    end
  endfunction : data_par

  // ------------
  // Pin synchronisers and protocol strap
  // ------------
  // Bus pins are synchronous to mclk; only the reset and strap pins are foreign
  logic [1:0] hrst_sync;
  logic [1:0] mode_sync;
  logic       hrst_prev;
  always_ff @(posedge mclk) begin
    if (rst) begin
      hrst_sync <= 2'h0;
      mode_sync <= 2'h3;
      hrst_prev <= 1'b0;
      extended_mode <= 1'b0;
    end else if (ce) begin
      hrst_sync <= {hrst_sync[0], hard_reset_n};
      mode_sync <= {mode_sync[0], bus_protocol_select_n};
      hrst_prev <= hrst_sync[1];
      if (hrst_sync[1] && !hrst_prev)
        extended_mode <= ~mode_sync[1];
    end
  end
  wire in_reset = rst | ~hrst_sync[1];

  // ------------
  // Transaction table: one slot per outstanding tenure
  // ------------
  typedef enum logic [1:0] {
    A_IDLE = 2'h0,
    A_REQ  = 2'h1,
    A_TERM = 2'h2
  } aphase_e;

  aphase_e                 astate;
  logic [DEPTH-1:0]        busy;
  logic [BEATS_W-1:0]      beats   [DEPTH];
  logic                    is_wr   [DEPTH];
  logic [DATA_W-1:0]       wr_data [DEPTH];
  logic [TXN_IDX_W-1:0]    head, tail, cur_slot;
  logic [BEATS_W-1:0]      beat_cnt;
  logic                    d_active;
  addr_bus_s               next_abus;
  logic                    push_pend;
  logic [ADDR_W-1:0]       push_addr;

  wire table_full  = busy[tail];
  wire ld_dep      = st_valid && (st_req.addr[ADDR_W-1:5] == ld_req.addr[ADDR_W-1:5]);
  wire ld_ok_dsi   = ld_valid && ld_req.direct_store;
  wire st_ok_dsi   = st_valid && st_req.direct_store;
  wire can_issue   = (astate == A_IDLE) && !table_full && !in_reset && !push_pend;
  wire take_ld     = can_issue && ld_valid && !ld_req.direct_store && !ld_dep;
  wire take_st     = can_issue && st_valid && !st_req.direct_store && !take_ld;
  wire push_go     = (astate == A_IDLE) && !table_full && push_pend && !in_reset;
  assign ld_ready  = take_ld || ld_ok_dsi;
  assign st_ready  = take_st || st_ok_dsi;

  // Attribute encoding per request
  wire core_req_s sel_req = take_ld ? ld_req : st_req;
  wire blk_move   = (sel_req.kind == REQ_CASTOUT) || (!sel_req.inhibited && !sel_req.write_thru
                    && sel_req.kind != REQ_BCAST && sel_req.kind != REQ_STORE);
  wire dbl_move   = extended_mode && (sel_req.vector || (sel_req.kind == REQ_FETCH && sel_req.inhibited));
  wire addr_only  = sel_req.kind == REQ_BCAST;
  wire [BEATS_W-1:0] sel_beats = addr_only ? 3'h0 : blk_move ? BEATS_BLOCK : dbl_move ? BEATS_DOUBLE
                                 : BEATS_SINGLE;
  wire sel_wr     = (sel_req.kind == REQ_STORE) || (sel_req.kind == REQ_CASTOUT);

  always_comb begin
    next_abus.addr  = push_go ? push_addr : sel_req.addr;
    next_abus.par   = addr_par(next_abus.addr);
    next_abus.ttype = push_go ? TT_WRITE : addr_only ? TT_ADDR_ONLY : sel_wr ? TT_WRITE : TT_READ;
    next_abus.tsize = (push_go || sel_beats != BEATS_SINGLE) ? SIZE_BLOCK : sel_req.size;
    next_abus.burst = push_go || (sel_beats > BEATS_SINGLE);
    next_abus.wt    = !push_go && sel_req.write_thru;
    next_abus.ci    = !push_go && sel_req.inhibited;
  end

  // ------------
  // Address tenure
  // ------------
  wire issue    = take_ld || take_st || push_go;
  wire a_ack    = (astate == A_TERM) && !addr_ack_n;
  wire a_retry  = a_ack && !address_retry_n;
  assign abus_req_n       = !(astate == A_REQ);
  assign abus_oe          = (astate == A_TERM);
  assign transfer_start_n = !(astate == A_REQ && !abus_grant_n);
  logic [BEATS_W-1:0] a_beats;
  logic               a_wr;
  logic [DATA_W-1:0]  a_data;

  always_ff @(posedge mclk) begin
    if (in_reset) begin
      astate   <= A_IDLE;
      abus_out <= '0;
      a_beats  <= 3'h0;
      a_wr     <= 1'b0;
      a_data   <= '0;
      tail     <= 4'h0;
      dsi_exc  <= 1'b0;
    end else if (ce) begin
      dsi_exc <= ld_ok_dsi || st_ok_dsi;
      case (astate)
        A_IDLE: if (issue) begin
          abus_out <= next_abus;
          a_beats  <= push_go ? BEATS_BLOCK : sel_beats;
          a_wr     <= push_go || sel_wr;
          a_data   <= st_data;
          astate   <= A_REQ;
        end
        A_REQ:  if (!abus_grant_n) astate <= A_TERM;
        A_TERM: if (a_retry) astate <= A_REQ;
          else if (a_ack) begin
            astate <= A_IDLE;
            if (a_beats != 3'h0) tail <= tail + 4'h1;
          end
        default: astate <= A_IDLE;
      endcase
    end
  end

  // Slot bookkeeping: enter at address close, leave at last beat
  wire a_close  = a_ack && !a_retry && (a_beats != 3'h0);
  wire d_beat   = d_active && !data_ack_n;
  wire d_repeat = d_beat && !data_retry_n;
  wire d_good   = d_beat && data_retry_n;
  wire d_last   = d_good && (beat_cnt == beats[cur_slot] - 3'h1);
  // Extended mode follows the target's index; legacy runs strictly in order
  wire [TXN_IDX_W-1:0] d_slot = extended_mode ? data_txn_index : head;

  always_ff @(posedge mclk) begin
    if (in_reset) begin
      busy <= '0;
      head <= 4'h0;
      for (int i = 0; i < DEPTH; i++) begin
        beats[i]   <= 3'h0;
        is_wr[i]   <= 1'b0;
        wr_data[i] <= '0;
      end
    end else if (ce) begin
      if (a_close) begin
        busy[tail]    <= 1'b1;
        beats[tail]   <= a_beats;
        is_wr[tail]   <= a_wr;
        wr_data[tail] <= a_data;
      end
      if (d_last) begin
        busy[cur_slot] <= 1'b0;
        if (!extended_mode) head <= head + 4'h1;
      end
    end
  end

  // ------------
  // Data tenure
  // ------------
  wire d_want = (extended_mode ? |busy : busy[head]) && !d_active;
  assign dbus_req_n = !d_want;
  assign dbus_oe    = d_active && is_wr[cur_slot];

  always_ff @(posedge mclk) begin
    if (in_reset) begin
      d_active     <= 1'b0;
      cur_slot     <= 4'h0;
      beat_cnt     <= 3'h0;
      rd_valid     <= 1'b0;
      rd_data      <= '0;
      rd_tag       <= 4'h0;
      dbus_out     <= '0;
      dbus_par_out <= '0;
      data_par_err <= 1'b0;
    end else if (ce) begin
      rd_valid     <= d_good && !is_wr[cur_slot];
      rd_data      <= dbus_in;
      rd_tag       <= cur_slot;
      data_par_err <= d_good && !is_wr[cur_slot] && (dbus_par_in != data_par(dbus_in));
      if (d_want && !dbus_grant_n && busy[d_slot]) begin
        d_active     <= 1'b1;
        cur_slot     <= d_slot;
        beat_cnt     <= 3'h0;
        dbus_out     <= wr_data[d_slot];
        dbus_par_out <= data_par(wr_data[d_slot]);
      end else if (d_last) begin
        d_active <= 1'b0;
      end else if (d_good) begin
        beat_cnt <= beat_cnt + 3'h1;
      end
    end
  end

  // ------------
  // Snoop: latch foreign address, probe caches, queue push on hit
  // ------------
  logic probe_wait;
  always_ff @(posedge mclk) begin
    if (in_reset) begin
      snoop_lookup <= 1'b0;
      snoop_addr   <= '0;
      probe_wait   <= 1'b0;
      push_pend    <= 1'b0;
      push_addr    <= '0;
      addr_par_err <= 1'b0;
    end else if (ce) begin
      snoop_lookup <= !snoop_ts_n && !abus_oe;
      probe_wait   <= snoop_lookup;
      addr_par_err <= !snoop_ts_n && !abus_oe && (abus_par_in != addr_par(abus_in));
      if (!snoop_ts_n && !abus_oe) snoop_addr <= abus_in;
      if (probe_wait && snoop_hit_mod) begin
        push_pend <= 1'b1;
        push_addr <= snoop_addr;
      end else if (push_go) begin
        push_pend <= 1'b0;
      end
    end
  end

  // ------------
  // Checks
  // ------------
  chk_ts_grant: assert property (@(posedge mclk) disable iff (in_reset)
    !transfer_start_n |-> !abus_grant_n && abus_req_n == 1'b0)
    else $error("transfer start without grant");
  chk_addr_par: assert property (@(posedge mclk) disable iff (in_reset)
    abus_oe |-> abus_out.par == addr_par(abus_out.addr))
    else $error("bad address parity driven");
  chk_data_par: assert property (@(posedge mclk) disable iff (in_reset)
    dbus_oe |-> dbus_par_out == data_par(dbus_out))
    else $error("bad data parity driven");
  chk_dsi_nobus: assert property (@(posedge mclk) disable iff (in_reset || !ce)
    (ld_ok_dsi && !st_valid) |=> dsi_exc && $stable(tail))
    else $error("direct store access reached bus");
  chk_retry_req: assert property (@(posedge mclk) disable iff (in_reset || !ce)
    a_retry |=> !abus_req_n)
    else $error("retry did not repeat address phase");
  chk_burst_attr: assert property (@(posedge mclk) disable iff (in_reset)
    abus_oe && abus_out.burst |-> abus_out.tsize == SIZE_BLOCK)
    else $error("burst attribute mismatch");
  chk_legacy_order: assert property (@(posedge mclk) disable iff (in_reset || !ce)
    (!extended_mode && d_last) |=> head == $past(head) + 4'h1)
    else $error("legacy tenure out of order");
  chk_load_first: assert property (@(posedge mclk) disable iff (in_reset)
    (can_issue && ld_valid && !ld_req.direct_store && !ld_dep) |-> !take_st)
    else $error("store passed eligible load");
  chk_push_issue: assert property (@(posedge mclk) disable iff (in_reset || !ce)
    (probe_wait && snoop_hit_mod) |=> push_pend)
    else $error("modified snoop hit lost");
  chk_full_hold: assert property (@(posedge mclk) disable iff (in_reset)
    table_full |-> !issue)
    else $error("issue beyond outstanding limit");
  cov_burst_read: cover property (@(posedge mclk) d_last && beats[cur_slot] == BEATS_BLOCK);
  cov_addr_retry: cover property (@(posedge mclk) a_retry);
  cov_snoop_push: cover property (@(posedge mclk) push_go);
  cov_data_rpt:   cover property (@(posedge mclk) d_repeat);
endmodule : sysbus_if_unit

// ---- hdl/sysbus_pkg.sv ----
// Shared constants and carrier types for the system bus interface
package sysbus_pkg;
  localparam int ADDR_W      = 36;
  localparam int ADDR_PAR_W  = 5;
  localparam int DATA_W      = 64;
  localparam int DATA_PAR_W  = 8;
  localparam int TXN_IDX_W   = 4;
  localparam int MAX_OUTSTD  = 16;
  localparam int TSIZE_W     = 4;
  localparam int TT_W        = 5;
  localparam int BEATS_W     = 3;
  localparam logic [2:0] BEATS_SINGLE = 3'h1;
  localparam logic [2:0] BEATS_DOUBLE = 3'h2;
  localparam logic [2:0] BEATS_BLOCK  = 3'h4;
  localparam logic [3:0] SIZE_BLOCK   = 4'h0;
  localparam logic [3:0] SIZE_DOUBLE  = 4'h0;
  localparam logic [4:0] TT_READ      = 5'h0a;
  localparam logic [4:0] TT_WRITE     = 5'h02;
  localparam logic [4:0] TT_ADDR_ONLY = 5'h00;

  typedef enum logic [2:0] {
    REQ_LOAD     = 3'h0,
    REQ_STORE    = 3'h1,
    REQ_FETCH    = 3'h2,
    REQ_CASTOUT  = 3'h3,
    REQ_PUSH     = 3'h4,
    REQ_BCAST    = 3'h5
  } req_kind_e;

  typedef struct packed {
    req_kind_e               kind;
    logic [ADDR_W-1:0]       addr;
    logic [TSIZE_W-1:0]      size;       // Bytes for single beat: 1,2,3,4,8
    logic                    vector;
    logic                    inhibited;
    logic                    write_thru;
    logic                    direct_store;
  } core_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0]       addr;
    logic [ADDR_PAR_W-1:0]   par;
    logic [TT_W-1:0]         ttype;
    logic [TSIZE_W-1:0]      tsize;
    logic                    burst;
    logic                    wt;
    logic                    ci;
  } addr_bus_s;

  function automatic logic odd_par8(input logic [7:0] v);
    return ~(^v);
  endfunction : odd_par8
endpackage : sysbus_pkg

// ---- sim/far_side.sv ----
// Far-side model: bus arbiters, address terminator and memory
`timescale 1ns/10ps
module far_side import sysbus_pkg::*; (
  input  wire logic                  mclk,            // Bus clock
  input  wire logic                  rst,             // Synchronous reset
  input  wire logic                  abus_req_n,      // Address bus request
  input  wire logic                  abus_oe,         // Design drives address
  input  wire logic                  dbus_req_n,      // Data bus request
  input  wire logic [2:0]            nbeats,          // Beats of next tenure
  input  wire logic                  retry_once,      // Retry next address once
  input  wire logic                  bad_par,         // Corrupt read parity
  output logic                       abus_grant_n,    // Address bus grant
  output logic                       addr_ack_n,      // Address termination
  output logic                       address_retry_n, // Address retry
  output logic                       dbus_grant_n,    // Data bus grant
  output logic                       data_ack_n,      // Beat termination
  output logic [DATA_W-1:0]          dbus_in,         // Read data
  output logic [DATA_PAR_W-1:0]      dbus_par_in,     // Read parity
  output logic [TXN_IDX_W-1:0]       data_txn_index,  // Returning tenure index
  output logic                       idle             // Nothing pending
);
  logic [2:0]        bq[$];
  logic [3:0]        tq[$];
  logic [2:0]        left, beat;
  logic [3:0]        issue;
  logic              retried, acking;
  logic [DATA_W-1:0] word;

  function automatic logic [DATA_PAR_W-1:0] pgen(input logic [DATA_W-1:0] w);
    for (int i = 0; i < DATA_PAR_W; i++) pgen[i] = ~^w[8*i +: 8];
  endfunction : pgen

  assign word   = {8'h5a, 53'h0, beat};
  assign acking = abus_oe && addr_ack_n;

  always_ff @(posedge mclk) begin
    if (rst) begin
      abus_grant_n    <= 1'b1;
      addr_ack_n      <= 1'b1;
      address_retry_n <= 1'b1;
      dbus_grant_n    <= 1'b1;
      data_ack_n      <= 1'b1;
      dbus_in         <= 64'h0;
      dbus_par_in     <= 8'h0;
      data_txn_index  <= 4'h0;
      left            <= 3'h0;
      issue           <= 4'h0;
      retried         <= 1'b0;
      idle            <= 1'b1;
      bq.delete();
      tq.delete();
    end else begin
      abus_grant_n    <= abus_req_n;
      addr_ack_n      <= !acking;
      address_retry_n <= !(acking && retry_once && !retried);
      retried         <= retry_once && (retried || acking);
      if (acking && !(retry_once && !retried) && nbeats != 3'h0) begin
        bq.push_back(nbeats);
        tq.push_back(issue);
        issue <= issue + 4'h1;
      end
      idle <= (left == 3'h0) && (bq.size() == 0);
      if (left == 3'h0) begin
        // Released bus inverts every cycle instead of holding the last beat
        data_ack_n   <= 1'b1;
        dbus_in      <= ~dbus_in;
        dbus_par_in  <= ~dbus_par_in;
        dbus_grant_n <= !(!dbus_req_n && bq.size() != 0);
        if (!dbus_req_n && bq.size() != 0) begin
          left           <= bq.pop_front();
          data_txn_index <= tq.pop_front();
          beat           <= 3'h0;
        end
      end else begin
        data_ack_n  <= 1'b0;
        dbus_in     <= word;
        dbus_par_in <= pgen(word) ^ {7'h0, bad_par};
        beat        <= beat + 3'h1;
        left        <= left - 3'h1;
      end
    end
  end
endmodule : far_side

// ---- sim/test_sysbus_if_unit.sv ----
// Self-checking bench for the system bus interface unit
`timescale 1ns/10ps
module test_sysbus_if_unit import sysbus_pkg::*;;
  logic mclk = 1'b0, ce = 1'b1, rst, hard_reset_n, bus_protocol_select_n;
  logic ld_valid = 1'b0, st_valid = 1'b0, snoop_ts_n = 1'b1, snoop_hit_mod = 1'b0, data_retry_n = 1'b1;
  logic retry_once = 1'b0, bad_par = 1'b0, hit_en = 1'b0, snoop_go = 1'b0, idle;
  logic [2:0] nbeats = 3'h1;
  core_req_s ld_req = '0, st_req = '0;
  logic [DATA_W-1:0] st_data = 64'h0123_4567_89ab_cdef, rd_data, dbus_out, dbus_in, wr, last_rd;
  logic [ADDR_W-1:0] abus_in = 36'h0, snoop_addr, first_a;
  logic [ADDR_PAR_W-1:0] abus_par_in = 5'h1f;
  logic [DATA_PAR_W-1:0] dbus_par_out, dbus_par_in, wpar;
  logic [TXN_IDX_W-1:0] rd_tag, data_txn_index, last_tag;
  addr_bus_s abus_out, ab;
  logic ld_ready, st_ready, dsi_exc, rd_valid, abus_req_n, abus_grant_n, transfer_start_n, abus_oe, addr_ack_n;
  logic address_retry_n, dbus_req_n, dbus_grant_n, dbus_oe, data_ack_n, snoop_lookup, extended_mode;
  logic addr_par_err, data_par_err;
  int err_total = 0, total_checks = 0, ts_cnt, rd_cnt, dsi_cnt, dpe_cnt, dreq_cnt, wr_cnt, lk_cnt, oe_cnt, ape_cnt;

  sysbus_if_unit i_sysbus_if_unit (.mclk, .rst, .ce, .hard_reset_n, .bus_protocol_select_n, .ld_valid, .ld_ready,
    .ld_req, .st_valid, .st_ready, .st_req, .st_data, .dsi_exc, .rd_valid, .rd_data, .rd_tag, .abus_req_n,
    .abus_grant_n, .transfer_start_n, .abus_out, .abus_oe, .abus_in, .abus_par_in, .snoop_ts_n, .addr_ack_n,
    .address_retry_n, .dbus_req_n, .dbus_grant_n, .dbus_out, .dbus_par_out, .dbus_oe, .dbus_in, .dbus_par_in,
    .data_ack_n, .data_retry_n, .data_txn_index, .snoop_lookup, .snoop_addr, .snoop_hit_mod, .extended_mode,
    .addr_par_err, .data_par_err);
  far_side i_far_side (.mclk, .rst, .abus_req_n, .abus_oe, .dbus_req_n, .nbeats, .retry_once, .bad_par,
    .abus_grant_n, .addr_ack_n, .address_retry_n, .dbus_grant_n, .data_ack_n, .dbus_in, .dbus_par_in,
    .data_txn_index, .idle);

  always #50 mclk = ~mclk;

  // ------------
  // Monitors and snoop driver
  // ------------
  always @(posedge mclk) begin
    if (transfer_start_n === 1'b0) ts_cnt++;
    if (rd_valid === 1'b1) begin
      rd_cnt++;
      last_rd = rd_data;
      last_tag = rd_tag;
    end
    if (dsi_exc === 1'b1) dsi_cnt++;
    if (data_par_err === 1'b1) dpe_cnt++;
    if (addr_par_err === 1'b1) ape_cnt++;
    if (dbus_req_n === 1'b0) dreq_cnt++;
    if (snoop_lookup === 1'b1) lk_cnt++;
    if (abus_oe === 1'b1) begin
      ab = abus_out;
      if (oe_cnt++ == 0) first_a = abus_out.addr;
    end
    if (dbus_oe === 1'b1 && data_ack_n === 1'b0) begin
      wr_cnt++;
      wr = dbus_out;
      wpar = dbus_par_out;
    end
  end

  // Foreign address only meaningful under snoop start; toggles otherwise
  always @(posedge mclk) begin
    snoop_ts_n    <= !snoop_go;
    abus_in       <= snoop_go ? 36'h9_8765_4320 : ~abus_in;
    snoop_hit_mod <= hit_en && snoop_lookup;
  end

  // ------------
  // Helpers
  // ------------
  function automatic logic [DATA_W-1:0] word(input logic [2:0] b);
    return {8'h5a, 53'h0, b};
  endfunction : word

  function automatic logic [DATA_PAR_W-1:0] pgen(input logic [DATA_W-1:0] w);
    for (int i = 0; i < DATA_PAR_W; i++) pgen[i] = ~^w[8*i +: 8];
  endfunction : pgen

  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic do_reset(input logic sel_n);
    rst <= 1'b1;
    hard_reset_n <= 1'b0;
    bus_protocol_select_n <= sel_n;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    hard_reset_n <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask : do_reset

  task automatic clr;
    @(negedge mclk);
    {ts_cnt, rd_cnt, dsi_cnt, dpe_cnt, dreq_cnt, wr_cnt, lk_cnt, oe_cnt, ape_cnt} = '0;
    @(posedge mclk);
  endtask : clr

  task automatic settle;
    int q;
    q = 0;
    for (int n = 0; n < 300 && q < 6; n++) begin
      @(posedge mclk);
      q = (abus_req_n && dbus_req_n && !abus_oe && idle) ? q + 1 : 0;
    end
    chk(q == 6, "bus never went idle");
  endtask : settle

  // Ready is a same-cycle pulse: look at mid-cycle, release after the edge
  task automatic run(input logic dl, input logic ds, input logic [2:0] nb);
    logic pl, ps;
    clr();
    pl = dl;
    ps = ds;
    nbeats <= nb;
    ld_valid <= dl;
    st_valid <= ds;
    for (int n = 0; n < 60 && (pl || ps); n++) begin
      @(negedge mclk);
      if (ld_ready === 1'b1) pl = 1'b0;
      if (st_ready === 1'b1) ps = 1'b0;
      @(posedge mclk);
      ld_valid <= pl;
      st_valid <= ps;
    end
    chk(!pl && !ps, "request never taken");
    settle();
  endtask : run

  // ------------
  // Scenarios
  // ------------
  task automatic t_single;
    ld_req <= core_req_s'{REQ_LOAD, 36'h0_1234_5678, 4'h8, 1'b0, 1'b1, 1'b0, 1'b0};
    run(1'b1, 1'b0, 3'h1);
    chk(ts_cnt == 1 && ab.addr === 36'h0_1234_5678, "address tenure");
    chk(ab.tsize === 4'h8 && ab.burst === 1'b0 && ab.ci === 1'b1, "single attributes");
    chk(rd_cnt == 1 && last_rd === word(3'h0), "single beat data");
    chk(last_tag === 4'h0, "read slot index");
  endtask : t_single

  task automatic t_bursts;
    ld_req <= core_req_s'{REQ_LOAD, 36'h0_0000_1000, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0};
    run(1'b1, 1'b0, 3'h4);
    chk(rd_cnt == 4 && last_rd === word(3'h3) && ab.burst === 1'b1, "block burst");
    ld_req <= core_req_s'{REQ_LOAD, 36'h0_0000_1100, 4'h0, 1'b1, 1'b1, 1'b0, 1'b0};
    run(1'b1, 1'b0, 3'h2);
    chk(rd_cnt == 2 && last_rd === word(3'h1) && last_tag === 4'h2, "two beat burst");
  endtask : t_bursts

  task automatic t_store;
    st_req <= core_req_s'{REQ_STORE, 36'h0_0000_2004, 4'h4, 1'b0, 1'b0, 1'b1, 1'b0};
    run(1'b0, 1'b1, 3'h1);
    chk(wr_cnt == 1 && wr === st_data && ab.wt === 1'b1, "write beat");
    chk(wpar === pgen(st_data), "write parity");
  endtask : t_store

  task automatic t_refusals;
    ld_req <= core_req_s'{REQ_LOAD, 36'h0_0000_5000, 4'h8, 1'b0, 1'b0, 1'b0, 1'b1};
    run(1'b1, 1'b0, 3'h0);
    chk(dsi_cnt == 1 && ts_cnt == 0, "direct-store exception");
    retry_once <= 1'b1;
    ld_req <= core_req_s'{REQ_LOAD, 36'h0_0000_6000, 4'h8, 1'b0, 1'b1, 1'b0, 1'b0};
    run(1'b1, 1'b0, 3'h1);
    chk(ts_cnt == 2 && rd_cnt == 1, "address retried");
    retry_once <= 1'b0;
    bad_par <= 1'b1;
    run(1'b1, 1'b0, 3'h1);
    chk(dpe_cnt == 1, "data parity flagged");
    bad_par <= 1'b0;
    st_req <= core_req_s'{REQ_BCAST, 36'h0_0000_7000, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0};
    run(1'b0, 1'b1, 3'h0);
    chk(ts_cnt == 1 && dreq_cnt == 0, "address only");
  endtask : t_refusals

  task automatic t_order(input logic [ADDR_W-1:0] la, input logic [ADDR_W-1:0] fa);
    ld_req <= core_req_s'{REQ_LOAD, la, 4'h8, 1'b0, 1'b1, 1'b0, 1'b0};
    st_req <= core_req_s'{REQ_STORE, 36'h0_0000_4000, 4'h8, 1'b0, 1'b1, 1'b0, 1'b0};
    run(1'b1, 1'b1, 3'h1);
    chk(first_a === fa && ts_cnt == 2, "load and store order");
  endtask : t_order

  task automatic t_snoop;
    hit_en <= 1'b1;
    nbeats <= 3'h4;
    clr();
    snoop_go <= 1'b1;
    @(posedge mclk);
    snoop_go <= 1'b0;
    settle();
    chk(lk_cnt == 1 && snoop_addr === 36'h9_8765_4320, "snoop latched");
    chk(ape_cnt == 1, "snoop address parity flagged");
    chk(ts_cnt == 1 && wr_cnt == 4, "snoop push");
    hit_en <= 1'b0;
  endtask : t_snoop

  initial begin
    do_reset(1'b0);
    chk(abus_req_n === 1'b1 && transfer_start_n === 1'b1 && abus_oe === 1'b0, "idle after reset");
    chk(extended_mode === 1'b1, "extended protocol latched");
    t_single();
    t_bursts();
    t_store();
    t_refusals();
    t_order(36'h0_0000_3000, 36'h0_0000_3000);
    t_order(36'h0_0000_4008, 36'h0_0000_4000);
    t_snoop();
    do_reset(1'b1);
    chk(extended_mode === 1'b0, "legacy protocol latched");
    t_single();
    end_sim();
  end

  initial begin
    #(5000 * 100);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule : test_sysbus_if_unit
